// ---- tb/adc_group_digital_config_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module adc_group_digital_config_tb_top;
    import grp_cfg_pkg::*;

    // ****************************************
    // stimulus and observed signals
    // ****************************************
    logic              clk_i  = 1'b0;   // 50 MHz bench clock
    logic              rst_i  = 1'b1;   // synchronous reset, held at start
    logic [ADDR_W-1:0] addr_i = 8'h00;  // register address
    logic [DATA_W-1:0] wdata_i = 16'h0000;
    logic              wr_i   = 1'b0;   // write strobe
    logic              rd_i   = 1'b0;   // read strobe
    logic              gain_en = 1'b0;  // global gain enable
    logic              ofs_en  = 1'b0;  // global offset enable
    logic              psel    = 1'b0;  // per-output pattern select
    logic [DATA_W-1:0] rdata_o;         // read data
    corr_cfg_t         corr;            // correction and filter controls
    logic              k_bad;           // corner out of range flag
    lane_pat_t         lane [4];        // per-output pattern controls
    logic [3:0]        pair_sel;        // input pair selects
    int                err_total   = 0; // mismatches seen
    int                checks_done = 0; // comparisons made

    always #10 clk_i = ~clk_i;

    adc_group_digital_config uut (
        .clk_i                       (clk_i),
        .rst_i                       (rst_i),
        .addr_i                      (addr_i),
        .wdata_i                     (wdata_i),
        .wr_i                        (wr_i),
        .rd_i                        (rd_i),
        .rdata_o                     (rdata_o),
        .global_gain_enable_i        (gain_en),
        .global_offset_enable_i      (ofs_en),
        .per_output_pattern_select_i (psel),
        .corr_o                      (corr),
        .corner_k_bad_o              (k_bad),
        .lane_o                      (lane),
        .input_pair_sel_o            (pair_sel)
    );

    // ****************************************
    // bus tasks and comparisons
    // ****************************************
    // strobe left high so writes can follow back to back; idle lowers it
    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_i);
        wr_i    <= 1'b1;
        rd_i    <= 1'b0;
        addr_i  <= a;
        wdata_i <= d;
    endtask : wr_reg

    // lowers strobes, lets the sampled write land, then settles
    task automatic idle();
        @(posedge clk_i);
        wr_i <= 1'b0;
        rd_i <= 1'b0;
        #1;
    endtask : idle

    task automatic chk_rd(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: read %h expected %h", $time, got, exp);
        end
    endtask : chk_rd

    task automatic chk_out(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: output %h expected %h", $time, got, exp);
        end
    endtask : chk_out

    // read data stands only in the cycle after the strobe
    task automatic rd_reg(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clk_i);
        rd_i   <= 1'b1;
        wr_i   <= 1'b0;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        chk_rd(rdata_o, exp);
    endtask : rd_reg

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : finish_test

    // ****************************************
    // watchdog
    // ****************************************
    // tests need under a hundred cycles; 5000 leaves wide margin
    initial begin
        #100000;
        err_total++;
        finish_test();
    end

    // ****************************************
    // test sequence
    // ****************************************
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        // reset values of all three registers
        rd_reg(GAIN_OFS_ADDR, 16'h0000);
        rd_reg(PAT_HPF_ADDR, 16'h0000);
        rd_reg(INSEL_PAT_ADDR, 16'h0000);
        @(posedge clk_i);
        #1;
        chk_rd(rdata_o, 16'h0000);
        chk_out({12'h000, pair_sel}, 16'h0000);
        // gain and offset, reserved bit dropped, back-to-back write and read
        gain_en <= 1'b1;
        ofs_en  <= 1'b1;
        wr_reg(GAIN_OFS_ADDR, 16'hffff);
        rd_reg(GAIN_OFS_ADDR, 16'hfbff);
        wr_reg(GAIN_OFS_ADDR, 16'h8a05);
        idle();
        chk_out({9'h000, corr.gain_on, corr.offset_on, corr.gain_n}, 16'h0071);
        chk_out({6'h00, corr.offset}, 16'h0205);
        gain_en <= 1'b0;
        idle();
        chk_out({10'h000, corr.gain_n, corr.gain_on}, 16'h0000);
        chk_out({6'h00, corr.offset}, 16'h0205);
        ofs_en <= 1'b0;
        idle();
        chk_out({5'h00, corr.offset, corr.offset_on}, 16'h0000);
        // prbs bit walks over outputs 1..4
        psel <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            wr_reg(PAT_HPF_ADDR, 16'h8000 >> i);
            idle();
            chk_out({12'h000, lane[0].prbs_en, lane[1].prbs_en, lane[2].prbs_en, lane[3].prbs_en},
                    16'h0008 >> i);
        end
        // codes for outputs 1,2 in one register, 3,4 and pairs in the other
        wr_reg(PAT_HPF_ADDR, 16'h0ac0);
        wr_reg(INSEL_PAT_ADDR, 16'hfac7);
        idle();
        chk_out({4'h0, lane[0], lane[1], 4'h0}, 16'h0530);
        chk_out({4'h0, lane[2], lane[3], 4'h0}, 16'h0610);
        chk_out({12'h000, pair_sel}, 16'h0005);
        rd_reg(INSEL_PAT_ADDR, 16'h0ac4);
        psel <= 1'b0;
        idle();
        chk_out({lane[0], lane[1], lane[2], lane[3]}, 16'h0000);
        // filter enable, rounding, corner at and beyond both limits
        wr_reg(PAT_HPF_ADDR, 16'h0035);
        idle();
        chk_out({10'h000, corr.filt_en, corr.corner_k, corr.round_en}, 16'h0035);
        chk_out({15'h0000, k_bad}, 16'h0000);
        wr_reg(PAT_HPF_ADDR, 16'h0023);
        idle();
        chk_out({11'h000, corr.filt_en, corr.corner_k}, 16'h0011);
        chk_out({15'h0000, k_bad}, 16'h0001);
        wr_reg(PAT_HPF_ADDR, 16'h0017);
        idle();
        chk_out({10'h000, corr.filt_en, corr.corner_k, corr.round_en}, 16'h0036);
        chk_out({15'h0000, k_bad}, 16'h0001);
        wr_reg(PAT_HPF_ADDR, 16'h0005);
        idle();
        chk_out({15'h0000, k_bad}, 16'h0000);
        wr_reg(PAT_HPF_ADDR, 16'h0014);
        idle();
        chk_out({15'h0000, corr.filt_en}, 16'h0000);
        // unmapped address: write ignored, read gives zero
        wr_reg(8'h16, 16'hffff);
        rd_reg(8'h16, 16'h0000);
        rd_reg(PAT_HPF_ADDR, 16'h0014);
        // second reset in mid-run clears everything again
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        #1;
        chk_out({12'h000, pair_sel}, 16'h0000);
        chk_out({10'h000, corr.filt_en, corr.corner_k, corr.round_en}, 16'h0000);
        rd_reg(GAIN_OFS_ADDR, 16'h0000);
        rd_reg(INSEL_PAT_ADDR, 16'h0000);
        finish_test();
    end

endmodule : adc_group_digital_config_tb_top
`default_nettype wire

// ---- verilog/adc_group_digital_config.sv ----
// Functional notes
// - gain field sets N times 0.2 dB
// - subtract ten-bit signed offset, 14-bit lsb
// - bits 15..12 put prbs on outputs 1..4
// - outputs 1,2 codes from bits 11-9, 8-6
// - outputs 3,4 codes from select register
// - bit 5 rounds filter output, else truncates
// - filter corner k in bits 4-1, 2..10
// - bit 0 enables high-pass filter, default off
// - bits 11..8 pick upper input pairs
// - all fields read zero after reset
//
// Our own choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module adc_group_digital_config
    import grp_cfg_pkg::*;
(
    // clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // register port
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [DATA_W-1:0] wdata_i,
    input  wire logic              wr_i,
    input  wire logic              rd_i,
    output logic [DATA_W-1:0]      rdata_o,
    // global enables from other registers
    input  wire logic              global_gain_enable_i,
    input  wire logic              global_offset_enable_i,
    input  wire logic              per_output_pattern_select_i,
    // correction and filter controls
    output corr_cfg_t              corr_o,
    output logic                   corner_k_bad_o,
    // test pattern controls, one per output
    output lane_pat_t              lane_o [4],
    // input pair selects, bit n-1 for converter n
    output logic [3:0]             input_pair_sel_o
);

    // ****************************************
    // register storage
    // ****************************************
    logic [15:0] gain_ofs_reg;    // even_gain_offset_ch4
    logic [15:0] pat_hpf_reg;     // pattern_and_hpf_ctrl
    logic [15:0] insel_pat_reg;   // input_pair_and_pattern_ctrl
    logic [15:0] rdata_next;      // read mux result
    bus_state_t  bus_reg;         // last bus action, for observation

    // writes; reserved bits are masked so they always read zero,
    // which keeps readback honest even if software ignores the zero rule
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gain_ofs_reg  <= REG_RESET_VAL;
            pat_hpf_reg   <= REG_RESET_VAL;
            insel_pat_reg <= REG_RESET_VAL;
        end else if (wr_i) begin
            case (addr_i)
                GAIN_OFS_ADDR:  gain_ofs_reg  <= wdata_i & GAIN_OFS_MASK;
                PAT_HPF_ADDR:   pat_hpf_reg   <= wdata_i & PAT_HPF_MASK;
                INSEL_PAT_ADDR: insel_pat_reg <= wdata_i & INSEL_PAT_MASK;
                default: ;      // unmapped write ignored
            endcase
        end
    end

    // read mux; unmapped addresses answer zero
    always_comb begin
        case (addr_i)
            GAIN_OFS_ADDR:  rdata_next = gain_ofs_reg;
            PAT_HPF_ADDR:   rdata_next = pat_hpf_reg;
            INSEL_PAT_ADDR: rdata_next = insel_pat_reg;
            default:        rdata_next = 16'h0000;
        endcase
    end

    // read data valid only the cycle after the strobe
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_o <= 16'h0000;
        end else if (rd_i) begin
            rdata_o <= rdata_next;
        end else begin
            rdata_o <= 16'h0000;
        end
    end

    // bus activity tracker
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bus_reg <= BUS_IDLE;
        end else begin
            case ({rd_i, wr_i})
                2'b01:   bus_reg <= BUS_WRITE;
                2'b10:   bus_reg <= BUS_READ;
                default: bus_reg <= BUS_IDLE;
            endcase
        end
    end

    // ****************************************
    // decoded controls
    // ****************************************
    grp_corr_cfg u_corr (
        .global_gain_enable_i   (global_gain_enable_i),
        .global_offset_enable_i (global_offset_enable_i),
        .gain_ofs_i             (gain_ofs_reg),
        .pat_hpf_i              (pat_hpf_reg),
        .corr_o                 (corr_o),
        .corner_k_bad_o         (corner_k_bad_o)
    );

    grp_pattern_sel u_pat (
        .per_output_pattern_select_i (per_output_pattern_select_i),
        .pat_hpf_i                   (pat_hpf_reg),
        .insel_pat_i                 (insel_pat_reg),
        .lane_o                      (lane_o)
    );

    // converter n takes bit 12-n; set means the upper pair
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            input_pair_sel_o[i] = insel_pat_reg[PAIR_LSB + 3 - i];
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    property p_gain_follows;
        @(posedge clk_i) disable iff (rst_i)
        (wr_i && addr_i == GAIN_OFS_ADDR && global_gain_enable_i) ##1 global_gain_enable_i
            |-> corr_o.gain_n == $past(wdata_i[15:11]);
    endproperty
    a_gain_follows: assert property (p_gain_follows) else $error("gain not taken");

    property p_offset_follows;
        @(posedge clk_i) disable iff (rst_i)
        (wr_i && addr_i == GAIN_OFS_ADDR && global_offset_enable_i) ##1 global_offset_enable_i
            |-> corr_o.offset == $past(wdata_i[9:0]);
    endproperty
    a_offset_follows: assert property (p_offset_follows) else $error("offset not taken");

    property p_prbs1;
        @(posedge clk_i) disable iff (rst_i)
        (wr_i && addr_i == PAT_HPF_ADDR) ##1 per_output_pattern_select_i
            |-> lane_o[0].prbs_en == $past(wdata_i[15]);
    endproperty
    a_prbs1: assert property (p_prbs1) else $error("prbs out1 wrong");

    property p_code2;
        @(posedge clk_i) disable iff (rst_i)
        (wr_i && addr_i == PAT_HPF_ADDR && per_output_pattern_select_i) ##1 per_output_pattern_select_i
            |-> lane_o[1].code == $past(wdata_i[8:6]);
    endproperty
    a_code2: assert property (p_code2) else $error("code out2 wrong");

    property p_code4;
        @(posedge clk_i) disable iff (rst_i)
        (wr_i && addr_i == INSEL_PAT_ADDR) ##1 per_output_pattern_select_i
            |-> lane_o[3].code == $past(wdata_i[4:2]);
    endproperty
    a_code4: assert property (p_code4) else $error("code out4 wrong");

    property p_round;
        @(posedge clk_i) disable iff (rst_i)
        (wr_i && addr_i == PAT_HPF_ADDR) |=> corr_o.round_en == $past(wdata_i[5]);
    endproperty
    a_round: assert property (p_round) else $error("round bit wrong");

    property p_corner;
        @(posedge clk_i) disable iff (rst_i)
        (wr_i && addr_i == PAT_HPF_ADDR) |=>
            corr_o.corner_k == $past(wdata_i[4:1]) && corr_o.filt_en == $past(wdata_i[0]);
    endproperty
    a_corner: assert property (p_corner) else $error("filter field wrong");

    property p_pair1;
        @(posedge clk_i) disable iff (rst_i)
        (wr_i && addr_i == INSEL_PAT_ADDR) |=> input_pair_sel_o[0] == $past(wdata_i[11]);
    endproperty
    a_pair1: assert property (p_pair1) else $error("pair select wrong");

    property p_reset_zero;
        @(posedge clk_i)
        $past(rst_i) |-> (gain_ofs_reg == 16'h0000 && pat_hpf_reg == 16'h0000 && insel_pat_reg == 16'h0000);
    endproperty
    a_reset_zero: assert property (p_reset_zero) else $error("reset value not zero");

    property p_reserved_zero;
        @(posedge clk_i) disable iff (rst_i)
        (rd_i && addr_i == INSEL_PAT_ADDR) |=> rdata_o[15:12] == 4'h0 && rdata_o[1:0] == 2'h0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit read one");

    property p_filter_en;
        @(posedge clk_i) disable iff (rst_i)
        $past(rst_i) |-> !corr_o.filt_en && !corner_k_bad_o;
    endproperty
    a_filter_en: assert property (p_filter_en) else $error("filter enable wrong");

    property p_read_back;
        @(posedge clk_i) disable iff (rst_i)
        (rd_i && addr_i == PAT_HPF_ADDR) |=> rdata_o == pat_hpf_reg;
    endproperty
    a_read_back: assert property (p_read_back) else $error("readback mismatch");

    property p_gain_gated;
        @(posedge clk_i) disable iff (rst_i)
        !global_gain_enable_i |-> corr_o.gain_n == 5'h00 && !corr_o.gain_on;
    endproperty
    a_gain_gated: assert property (p_gain_gated) else $error("gain not gated");

    property p_offset_gated;
        @(posedge clk_i) disable iff (rst_i)
        !global_offset_enable_i |-> corr_o.offset == 10'h000 && !corr_o.offset_on;
    endproperty
    a_offset_gated: assert property (p_offset_gated) else $error("offset not gated");

    property p_prbs2;
        @(posedge clk_i) disable iff (rst_i)
        (wr_i && addr_i == PAT_HPF_ADDR) ##1 per_output_pattern_select_i
            |-> lane_o[1].prbs_en == $past(wdata_i[14]);
    endproperty
    a_prbs2: assert property (p_prbs2) else $error("prbs out2 wrong");

    property p_prbs3;
        @(posedge clk_i) disable iff (rst_i)
        (wr_i && addr_i == PAT_HPF_ADDR) ##1 per_output_pattern_select_i
            |-> lane_o[2].prbs_en == $past(wdata_i[13]);
    endproperty
    a_prbs3: assert property (p_prbs3) else $error("prbs out3 wrong");

    property p_prbs4;
        @(posedge clk_i) disable iff (rst_i)
        (wr_i && addr_i == PAT_HPF_ADDR) ##1 per_output_pattern_select_i
            |-> lane_o[3].prbs_en == $past(wdata_i[12]);
    endproperty
    a_prbs4: assert property (p_prbs4) else $error("prbs out4 wrong");

    property p_prbs_gated;
        @(posedge clk_i) disable iff (rst_i)
        !per_output_pattern_select_i |->
            !lane_o[0].prbs_en && !lane_o[1].prbs_en && !lane_o[2].prbs_en && !lane_o[3].prbs_en;
    endproperty
    a_prbs_gated: assert property (p_prbs_gated) else $error("prbs not gated");

    property p_code1;
        @(posedge clk_i) disable iff (rst_i)
        (wr_i && addr_i == PAT_HPF_ADDR) ##1 per_output_pattern_select_i
            |-> lane_o[0].code == $past(wdata_i[11:9]);
    endproperty
    a_code1: assert property (p_code1) else $error("code out1 wrong");

    property p_code3;
        @(posedge clk_i) disable iff (rst_i)
        (wr_i && addr_i == INSEL_PAT_ADDR) ##1 per_output_pattern_select_i
            |-> lane_o[2].code == $past(wdata_i[7:5]);
    endproperty
    a_code3: assert property (p_code3) else $error("code out3 wrong");

    property p_code_gated;
        @(posedge clk_i) disable iff (rst_i)
        !per_output_pattern_select_i |->
            lane_o[0].code == 3'h0 && lane_o[1].code == 3'h0 && lane_o[2].code == 3'h0 && lane_o[3].code == 3'h0;
    endproperty
    a_code_gated: assert property (p_code_gated) else $error("codes not gated");

    property p_pair_mid;
        @(posedge clk_i) disable iff (rst_i)
        (wr_i && addr_i == INSEL_PAT_ADDR) |=>
            {input_pair_sel_o[1], input_pair_sel_o[2]} == $past(wdata_i[10:9]);
    endproperty
    a_pair_mid: assert property (p_pair_mid) else $error("pair select 2,3 wrong");

    property p_pair4;
        @(posedge clk_i) disable iff (rst_i)
        (wr_i && addr_i == INSEL_PAT_ADDR) |=> input_pair_sel_o[3] == $past(wdata_i[8]);
    endproperty
    a_pair4: assert property (p_pair4) else $error("pair select 4 wrong");

    property p_k_bad;
        @(posedge clk_i) disable iff (rst_i)
        (wr_i && addr_i == PAT_HPF_ADDR && wdata_i[0]
            && (wdata_i[4:1] < CORNER_K_MIN || wdata_i[4:1] > CORNER_K_MAX)) |=> corner_k_bad_o;
    endproperty
    a_k_bad: assert property (p_k_bad) else $error("illegal k not flagged");

    property p_k_good;
        @(posedge clk_i) disable iff (rst_i)
        (wr_i && addr_i == PAT_HPF_ADDR && !(wdata_i[0]
            && (wdata_i[4:1] < CORNER_K_MIN || wdata_i[4:1] > CORNER_K_MAX))) |=> !corner_k_bad_o;
    endproperty
    a_k_good: assert property (p_k_good) else $error("legal k flagged");

    property p_reserved_gain;
        @(posedge clk_i) disable iff (rst_i)
        (rd_i && addr_i == GAIN_OFS_ADDR) |=> !rdata_o[10];
    endproperty
    a_reserved_gain: assert property (p_reserved_gain) else $error("reserved gain bit read one");

    // read data must not linger past its answer cycle
    property p_rdata_idle;
        @(posedge clk_i) disable iff (rst_i)
        !rd_i |=> rdata_o == 16'h0000;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside answer cycle");

    c_write_gain: cover property (@(posedge clk_i) wr_i && addr_i == GAIN_OFS_ADDR);
    c_read_after_write: cover property (@(posedge clk_i) wr_i ##1 rd_i);
    c_prbs_all: cover property (@(posedge clk_i) per_output_pattern_select_i && pat_hpf_reg[15:12] == 4'hf);
    c_bad_k: cover property (@(posedge clk_i) corner_k_bad_o);
    c_bus_read: cover property (@(posedge clk_i) bus_reg == BUS_READ);

endmodule : adc_group_digital_config
`default_nettype wire

// ---- verilog/grp_cfg_pkg.sv ----
package grp_cfg_pkg;

    // ****************************************
    // register map
    // ****************************************
    localparam int          ADDR_W          = 8;             // register address width
    localparam int          DATA_W          = 16;            // register data width
    localparam logic [7:0]  GAIN_OFS_ADDR   = 8'h14;         // even_gain_offset_ch4
    localparam logic [7:0]  PAT_HPF_ADDR    = 8'h15;         // pattern_and_hpf_ctrl
    localparam logic [7:0]  INSEL_PAT_ADDR  = 8'h17;         // input_pair_and_pattern_ctrl
    localparam logic [15:0] REG_RESET_VAL   = 16'h0000;      // all fields zero after reset

    // ****************************************
    // field positions
    // ****************************************
    localparam int GAIN_LSB      = 11;  // even_gain_ch4 15-11
    localparam int GAIN_W        = 5;
    localparam int OFS_LSB       = 0;   // even_offset_ch4 9-0
    localparam int OFS_W         = 10;
    localparam int PRBS_LSB      = 12;  // prbs_on_out4..1 at 12..15
    localparam int PCODE1_LSB    = 9;   // pattern_code_out1 11-9
    localparam int PCODE2_LSB    = 6;   // pattern_code_out2 8-6
    localparam int ROUND_BIT     = 5;   // filter_round_enable_grp
    localparam int CORNER_LSB    = 1;   // filter_corner_k_grp 4-1
    localparam int CORNER_W      = 4;
    localparam int FILT_EN_BIT   = 0;   // filter_enable_grp
    localparam int PAIR_LSB      = 8;   // input_pair_sel_ch4..1 at 8..11
    localparam int PCODE3_LSB    = 5;   // pattern_code_out3 7-5
    localparam int PCODE4_LSB    = 2;   // pattern_code_out4 4-2
    localparam int PCODE_W       = 3;

    // writable masks: reserved positions keep zero
    localparam logic [15:0] GAIN_OFS_MASK  = 16'hfbff;
    localparam logic [15:0] PAT_HPF_MASK   = 16'hffff;
    localparam logic [15:0] INSEL_PAT_MASK = 16'h0ffc;

    // ****************************************
    // corner limits and carriers
    // ****************************************
    localparam logic [3:0] CORNER_K_MIN = 4'h2;
    localparam logic [3:0] CORNER_K_MAX = 4'ha;

    typedef enum logic [1:0] {
        BUS_IDLE  = 2'b00,
        BUS_WRITE = 2'b01,
        BUS_READ  = 2'b11
    } bus_state_t;

    // test pattern controls for one output
    typedef struct packed {
        logic       prbs_en;   // pseudo-random pattern switched on
        logic [2:0] code;      // pattern code
    } lane_pat_t;

    // correction and filter controls
    typedef struct packed {
        logic [4:0] gain_n;      // gain steps of 0.2 dB
        logic [9:0] offset;      // two's complement, 14-bit lsb
        logic       gain_on;     // gain applied
        logic       offset_on;   // offset applied
        logic       filt_en;     // filter enabled
        logic [3:0] corner_k;    // filter corner k
        logic       round_en;    // round instead of truncate
    } corr_cfg_t;

    // field extraction used in several places
    function automatic logic [2:0] field3(input logic [15:0] word, input int lsb);
        field3 = word[lsb +: 3];
    endfunction : field3

endpackage : grp_cfg_pkg

// ---- verilog/grp_corr_cfg.sv ----
`timescale 1ns/1ps
`default_nettype none
module grp_corr_cfg
    import grp_cfg_pkg::*;
(
    // control
    input  wire logic              global_gain_enable_i,
    input  wire logic              global_offset_enable_i,
    input  wire logic [15:0]       gain_ofs_i,
    input  wire logic [15:0]       pat_hpf_i,
    // decoded controls
    output corr_cfg_t              corr_o,
    output logic                   corner_k_bad_o
);

    // ****************************************
    // correction and filter decode
    // ****************************************
    always_comb begin
        corr_o.gain_n    = global_gain_enable_i ? gain_ofs_i[GAIN_LSB +: GAIN_W] : 5'h00;
        corr_o.gain_on   = global_gain_enable_i;
        corr_o.offset    = global_offset_enable_i ? gain_ofs_i[OFS_LSB +: OFS_W] : 10'h000;
        corr_o.offset_on = global_offset_enable_i;
        corr_o.filt_en   = pat_hpf_i[FILT_EN_BIT];
        corr_o.corner_k  = pat_hpf_i[CORNER_LSB +: CORNER_W];
        corr_o.round_en  = pat_hpf_i[ROUND_BIT];
    end

    // flags an illegal k while the filter runs; software must avoid it
    assign corner_k_bad_o = pat_hpf_i[FILT_EN_BIT]
                          & ((pat_hpf_i[CORNER_LSB +: CORNER_W] < CORNER_K_MIN)
                          |  (pat_hpf_i[CORNER_LSB +: CORNER_W] > CORNER_K_MAX));

endmodule : grp_corr_cfg
`default_nettype wire

// ---- verilog/grp_pattern_sel.sv ----
`timescale 1ns/1ps
`default_nettype none
module grp_pattern_sel
    import grp_cfg_pkg::*;
(
    // control
    input  wire logic              per_output_pattern_select_i,
    input  wire logic [15:0]       pat_hpf_i,
    input  wire logic [15:0]       insel_pat_i,
    // lane controls
    output lane_pat_t              lane_o [4]
);

    // ****************************************
    // per-output pattern controls
    // ****************************************
    // gated so lanes see nothing unless individual selection is on
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            lane_o[i].prbs_en = per_output_pattern_select_i & pat_hpf_i[PRBS_LSB + 3 - i];
        end
        lane_o[0].code = per_output_pattern_select_i ? field3(pat_hpf_i, PCODE1_LSB) : 3'h0;
        lane_o[1].code = per_output_pattern_select_i ? field3(pat_hpf_i, PCODE2_LSB) : 3'h0;
        lane_o[2].code = per_output_pattern_select_i ? field3(insel_pat_i, PCODE3_LSB) : 3'h0;
        lane_o[3].code = per_output_pattern_select_i ? field3(insel_pat_i, PCODE4_LSB) : 3'h0;
    end

endmodule : grp_pattern_sel
`default_nettype wire
